// File: bench/artc_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "artc_regs.svh"
module artc_timer_tb
    import artc_pkg::*;
;
    logic clock;
    logic reset_n;
    artc_byte_t reg_addr;
    artc_byte_t reg_wdata;
    logic reg_write;
    logic reg_read;
    artc_byte_t reg_rdata;
    logic irq_flag;
    logic pin_out;
    logic pin_oe;
    int bad_count;
    int checks;
    int fl;
    int hi;
    artc_byte_t rv;

    artc_timer uut (
        .clock(clock),
        .reset_n(reset_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .overflow_irq_flag(irq_flag),
        .buzzer_pin_out(pin_out),
        .buzzer_pin_oe(pin_oe)
    );

    // 250 MHz system clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input artc_byte_t got, input artc_byte_t exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe, sampled at the second edge
    task automatic wr(input artc_byte_t a, input artc_byte_t d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rchk(input artc_byte_t a, input artc_byte_t exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        rv = reg_rdata;
        chk(rv, exp);
    endtask

    // Count pin transitions and high cycles over n edges
    task automatic watch(input int n);
        logic last;
        fl = 0;
        hi = 0;
        #1;
        last = pin_out;
        repeat (n) begin
            @(posedge clock);
            #1;
            if (pin_out !== last) fl++;
            if (pin_out === 1'b1) hi++;
            last = pin_out;
        end
    endtask

    // Start at 0xfc, rate 111: two ticks per four clocks
    task automatic ovf(input logic aload, input logic ien);
        wr(`ARTC_MODE_OFS, {5'b11110, aload, 2'b00});
        wr(`ARTC_IRQ_OFS, {7'h00, ien});
        wr(`ARTC_RELOAD_OFS, 8'h40);
        wr(`ARTC_COUNT_OFS, 8'hfc);
        repeat (5) @(posedge clock);
        #1;
        chk({7'h00, irq_flag}, 8'h00);
        repeat (3) @(posedge clock);
        #1;
        chk({7'h00, irq_flag}, {7'h00, ien});
        repeat (3) @(posedge clock);
        rchk(`ARTC_COUNT_OFS, aload ? 8'h42 : 8'h02);
        chk({7'h00, irq_flag}, {7'h00, ien});
        wr(`ARTC_MODE_OFS, 8'h00);
        wr(`ARTC_IRQ_OFS, 8'h01);
        #1;
        chk({7'h00, irq_flag}, 8'h00);
    endtask

    // Hang guard, well beyond the few thousand cycles needed
    initial begin
        #100000;
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end

    initial begin
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        #1;
        chk({6'h00, pin_oe, irq_flag}, 8'h00);
        rchk(`ARTC_MODE_OFS, 8'h00);
        rchk(`ARTC_COUNT_OFS, 8'h00);
        rchk(8'h10, 8'h00);
        wr(`ARTC_MODE_OFS, 8'h75);
        rchk(`ARTC_MODE_OFS, 8'h75);
        // Read data must fall back to zero one cycle later
        @(posedge clock);
        #1;
        chk(reg_rdata, 8'h00);
        wr(`ARTC_MODE_OFS, 8'h00);
        wr(`ARTC_RELOAD_OFS, 8'h55);
        rchk(`ARTC_RELOAD_OFS, 8'h00);
        wr(`ARTC_COUNT_OFS, 8'h3c);
        rchk(`ARTC_COUNT_OFS, 8'h3c);
        // Exactly three ticks fit any window of three periods
        for (int r = 0; r < 8; r++) begin
            wr(`ARTC_MODE_OFS, 8'h80 | artc_byte_t'(r << 4));
            wr(`ARTC_COUNT_OFS, 8'h00);
            repeat (3 * (256 >> r) - 1) @(posedge clock);
            rchk(`ARTC_COUNT_OFS, 8'h03);
        end
        ovf(1'b0, 1'b1);
        ovf(1'b1, 1'b1);
        ovf(1'b0, 1'b0);
        // Toggle: reload 0xfe gives an overflow every four clocks
        wr(`ARTC_MODE_OFS, 8'h00);
        wr(`ARTC_RELOAD_OFS, 8'hfe);
        wr(`ARTC_MODE_OFS, 8'hf6);
        wr(`ARTC_COUNT_OFS, 8'hfe);
        watch(16);
        chk(artc_byte_t'(fl), 8'h04);
        chk({7'h00, pin_oe}, 8'h01);
        // PWM: one full counter cycle, high while count below 0x40
        wr(`ARTC_MODE_OFS, 8'h00);
        wr(`ARTC_RELOAD_OFS, 8'h40);
        wr(`ARTC_MODE_OFS, 8'hf1);
        wr(`ARTC_COUNT_OFS, 8'h00);
        watch(512);
        chk(artc_byte_t'(hi), 8'h80);
        chk({7'h00, pin_oe}, 8'h01);
        // Run bit low freezes count and forces output low
        wr(`ARTC_MODE_OFS, 8'h71);
        wr(`ARTC_COUNT_OFS, 8'h10);
        watch(16);
        chk(artc_byte_t'(hi), 8'h00);
        rchk(`ARTC_COUNT_OFS, 8'h10);
        wr(`ARTC_MODE_OFS, 8'h00);
        #1;
        chk({7'h00, pin_oe}, 8'h00);
        close_out();
    end
endmodule
`default_nettype wire

// File: verilog/artc_pkg.sv
`default_nettype none
package artc_pkg;
    typedef logic [7:0] artc_byte_t;
    typedef logic [2:0] artc_rate_t;
    // Who owns the shared pin
    typedef enum logic [1:0] {
        ARTC_PIN_GPIO,
        ARTC_PIN_TOGGLE,
        ARTC_PIN_PWM
    } artc_pin_e;
endpackage
`default_nettype wire

// File: verilog/artc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "artc_regs.svh"
module artc_prescaler
    import artc_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire artc_rate_t rate,
    output logic tick
);
    artc_byte_t div_q;
    artc_byte_t div_d;
    artc_byte_t mask;

    // Free-running divider; mask of low bits picks 256 >> rate
    always_comb begin
        div_d = div_q + 8'h01;
        mask = `ARTC_DIV_MAX >> rate;
        tick = ((div_q & mask) == mask); // [R2]
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_d;
        end
    end

    // No stable rate ticks back to back; the divide-by-2 setting is left unchecked
    tick_spacing_a: assert property (@(posedge clock) // [R2]
        disable iff (!reset_n)
        (tick && rate != 3'h7 && $stable(rate)) |=> !tick)
        else $error("prescaler ticked twice in a row");
endmodule
`default_nettype wire

// File: verilog/artc_regs.svh
// Behaviour
// R1 - Count advances by one per prescaled tick, only while running.
// R2 - Rate code 000 divides clock by 256, each step halves, 111 by 2.
// R3 - Mode register resets to zero: stopped, slowest rate, all off.
// R4 - Mode bit 7 runs counter, toggle output and PWM output together.
// R5 - Count 0xff steps to 0x00 on the next tick and flags overflow.
// R6 - Overflow with interrupt enable set raises the interrupt flag.
// R7 - Mode bit 2 chooses wrap to zero or reload after overflow.
// R8 - With reload on, overflow copies reload value into the count.
// R9 - Mode bit 1 puts toggle on shared pin, frees GPIO, kills PWM.
// R10 - Mode bit 0 enables PWM on pin; software keeps bit 1 clear then.
// R11 - Reload register also holds the PWM duty value.
// R12 - Software loads a start count each time it starts the timer.
// R13 - Software always writes zero to mode bit 3.
// R14 - Software runs timer and sets reload before using toggle output.
// R15 - Count register is read/write; its reset content is undefined.
// R16 - Start value to overflow takes 256 minus start value ticks.
// R17 - Toggle and PWM go only to the single shared pin.
// R18 - Toggle output flips once per overflow, half the overflow rate.
// R19 - Reload register is write-only; reads return zero.
// R20 - PWM output high while running count is below duty value.
`ifndef ARTC_REGS_SVH
`define ARTC_REGS_SVH

// Register offsets on the 8-bit register port
`define ARTC_RELOAD_OFS 8'hcd
`define ARTC_MODE_OFS 8'hda
`define ARTC_COUNT_OFS 8'hdb
`define ARTC_IRQ_OFS 8'hdc

// Mode register fields
`define ARTC_RUN_BIT 7
`define ARTC_RATE_HI 6
`define ARTC_RATE_LO 4
`define ARTC_ALOAD_BIT 2
`define ARTC_TOGGLE_BIT 1
`define ARTC_PWM_BIT 0
`define ARTC_MODE_MASK 8'hf7

// Interrupt register fields
`define ARTC_IEN_BIT 0
`define ARTC_IRQ_BIT 1

// Reset values and counter limits
`define ARTC_MODE_RST 8'h00
`define ARTC_COUNT_RST 8'h00
`define ARTC_RELOAD_RST 8'h00
`define ARTC_COUNT_MAX 8'hff
`define ARTC_DIV_MAX 8'hff

`endif

// File: verilog/artc_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "artc_regs.svh"
module artc_timer
    import artc_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire artc_byte_t reg_addr,
    input wire artc_byte_t reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output artc_byte_t reg_rdata,
    output logic overflow_irq_flag,
    output logic buzzer_pin_out,
    output logic buzzer_pin_oe
);
    artc_byte_t mode_q;
    artc_byte_t mode_d;
    artc_byte_t count_q;
    artc_byte_t count_d;
    artc_byte_t reload_q;
    artc_byte_t reload_d;
    artc_byte_t rdata_q;
    artc_byte_t rdata_d;
    logic irq_en_q;
    logic irq_en_d;
    logic irq_q;
    logic irq_d;
    logic toggle_q;
    logic toggle_d;
    logic pwm_q;
    logic pwm_d;
    logic tick;
    logic overflow;
    logic timer_run_bit;
    logic auto_reload_bit;
    logic toggle_output_enable;
    logic pwm_output_enable;
    logic wr_mode;
    logic wr_count;
    logic wr_reload;
    logic wr_irq;
    artc_rate_t prescale_select_field;
    artc_pin_e pin_owner;

    // Field decode of the mode register
    assign timer_run_bit = mode_q[`ARTC_RUN_BIT];
    assign prescale_select_field = mode_q[`ARTC_RATE_HI:`ARTC_RATE_LO];
    assign auto_reload_bit = mode_q[`ARTC_ALOAD_BIT];
    assign toggle_output_enable = mode_q[`ARTC_TOGGLE_BIT];
    assign pwm_output_enable = mode_q[`ARTC_PWM_BIT];

    // Write strobes per register
    assign wr_mode = reg_write && (reg_addr == `ARTC_MODE_OFS);
    assign wr_count = reg_write && (reg_addr == `ARTC_COUNT_OFS);
    assign wr_reload = reg_write && (reg_addr == `ARTC_RELOAD_OFS);
    assign wr_irq = reg_write && (reg_addr == `ARTC_IRQ_OFS);

    artc_prescaler u_prescaler (
        .clock(clock),
        .reset_n(reset_n),
        .rate(prescale_select_field), // [R2]
        .tick(tick)
    );

    // Overflow on the tick that leaves 0xff; a software write to the
    // count in the same cycle wins and the tick is dropped
    assign overflow = tick && timer_run_bit && !wr_count &&
        (count_q == `ARTC_COUNT_MAX); // [R5] [R16]

    // Configuration registers; bit 3 is kept at zero regardless
    always_comb begin
        mode_d = mode_q;
        reload_d = reload_q;
        irq_en_d = irq_en_q;
        if (wr_mode) begin
            mode_d = reg_wdata & `ARTC_MODE_MASK;
        end
        if (wr_reload) begin
            reload_d = reg_wdata; // [R11]
        end
        if (wr_irq) begin
            irq_en_d = reg_wdata[`ARTC_IEN_BIT];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= `ARTC_MODE_RST; // [R3]
            reload_q <= `ARTC_RELOAD_RST;
            irq_en_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            reload_q <= reload_d;
            irq_en_q <= irq_en_d;
        end
    end

    // Counter: software load, then tick, overflow wraps or reloads
    always_comb begin
        count_d = count_q;
        if (wr_count) begin
            count_d = reg_wdata; // [R15]
        end else if (overflow) begin
            if (auto_reload_bit) begin
                count_d = reload_q; // [R7] [R8]
            end else begin
                count_d = 8'h00; // [R5] [R7]
            end
        end else if (tick && timer_run_bit) begin
            count_d = count_q + 8'h01; // [R1] [R4]
        end
    end

    // Content is undefined to software; cleared here for clean sims
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= `ARTC_COUNT_RST;
        end else begin
            count_q <= count_d;
        end
    end

    // Software write lands whatever the prescaler is doing
    count_load_a: assert property (@(posedge clock) // [R15]
        disable iff (!reset_n)
        wr_count |=> count_q == $past(reg_wdata))
        else $error("count write did not land");

    // Interrupt flag: set beats a software clear in the same cycle
    always_comb begin
        irq_d = irq_q;
        if (wr_irq && !reg_wdata[`ARTC_IRQ_BIT]) begin
            irq_d = 1'b0;
        end
        if (overflow && irq_en_q) begin
            irq_d = 1'b1; // [R6]
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // Flag stands until software clears it
    irq_keep_a: assert property (@(posedge clock) // [R6]
        disable iff (!reset_n)
        (irq_q && !(wr_irq && !reg_wdata[`ARTC_IRQ_BIT]))
        |=> overflow_irq_flag)
        else $error("interrupt flag dropped by itself");

    irq_quiet_a: assert property (@(posedge clock) // [R6]
        disable iff (!reset_n)
        (!irq_q && !(overflow && irq_en_q)) |=> !overflow_irq_flag)
        else $error("interrupt flag rose without overflow");

    assign overflow_irq_flag = irq_q;

    // Waveforms: toggle flips per overflow; PWM compares count to duty.
    // Both stop low when the run bit clears so the pin idles quietly.
    always_comb begin
        toggle_d = toggle_q;
        pwm_d = 1'b0;
        if (!timer_run_bit) begin
            toggle_d = 1'b0; // [R4]
        end else if (overflow) begin
            toggle_d = !toggle_q; // [R18]
        end
        if (timer_run_bit && pwm_output_enable && !toggle_output_enable) begin
            pwm_d = (count_q < reload_q); // [R20] [R11] [R9]
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            toggle_q <= 1'b0;
            pwm_q <= 1'b0;
        end else begin
            toggle_q <= toggle_d;
            pwm_q <= pwm_d;
        end
    end

    // A stopped timer leaves both waveforms low
    run_quiet_a: assert property (@(posedge clock) // [R4]
        disable iff (!reset_n)
        !timer_run_bit |=> (!toggle_q && !pwm_q))
        else $error("waveform moved while stopped");

    // Shared pin takeover; toggle has priority over PWM
    always_comb begin
        if (toggle_output_enable) begin
            pin_owner = ARTC_PIN_TOGGLE; // [R9]
        end else if (pwm_output_enable) begin
            pin_owner = ARTC_PIN_PWM; // [R10]
        end else begin
            pin_owner = ARTC_PIN_GPIO;
        end
    end

    always_comb begin
        case (pin_owner)
            ARTC_PIN_TOGGLE: begin
                buzzer_pin_out = toggle_q; // [R17]
                buzzer_pin_oe = 1'b1;
            end
            ARTC_PIN_PWM: begin
                buzzer_pin_out = pwm_q; // [R17]
                buzzer_pin_oe = 1'b1;
            end
            default: begin
                buzzer_pin_out = 1'b0;
                buzzer_pin_oe = 1'b0;
            end
        endcase
    end

    pin_pwm_a: assert property (@(posedge clock) // [R10]
        disable iff (!reset_n)
        (pwm_output_enable && !toggle_output_enable) |->
        (buzzer_pin_oe && buzzer_pin_out == pwm_q))
        else $error("pwm does not own the pin");

    pin_free_a: assert property (@(posedge clock) // [R9]
        disable iff (!reset_n)
        (!pwm_output_enable && !toggle_output_enable) |->
        (!buzzer_pin_oe && !buzzer_pin_out))
        else $error("pin held with both outputs off");

    // Read port; reload reads as zero, unmapped reads as zero
    always_comb begin
        rdata_d = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                `ARTC_MODE_OFS: rdata_d = mode_q;
                `ARTC_COUNT_OFS: rdata_d = count_q; // [R15]
                `ARTC_IRQ_OFS: rdata_d = {6'h00, irq_q, irq_en_q};
                `ARTC_RELOAD_OFS: rdata_d = 8'h00; // [R19]
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    count_read_a: assert property (@(posedge clock) // [R15]
        disable iff (!reset_n)
        (reg_read && reg_addr == `ARTC_COUNT_OFS) |=>
        reg_rdata == $past(count_q))
        else $error("count read returned wrong value");

    assign reg_rdata = rdata_q;

    // Checks on the counting path
    count_step_a: assert property (@(posedge clock) // [R1]
        disable iff (!reset_n)
        (tick && timer_run_bit && !wr_count && count_q != 8'hff)
        |=> count_q == $past(count_q) + 8'h01)
        else $error("count did not step by one");

    count_hold_a: assert property (@(posedge clock) // [R4]
        disable iff (!reset_n)
        (!timer_run_bit && !wr_count) |=> $stable(count_q))
        else $error("count moved while stopped");

    wrap_zero_a: assert property (@(posedge clock) // [R5]
        disable iff (!reset_n)
        (overflow && !auto_reload_bit) |=> count_q == 8'h00)
        else $error("overflow did not wrap to zero");

    reload_load_a: assert property (@(posedge clock) // [R8]
        disable iff (!reset_n)
        (overflow && auto_reload_bit) |=> count_q == $past(reload_q))
        else $error("overflow did not reload count");

    irq_set_a: assert property (@(posedge clock) // [R6]
        disable iff (!reset_n)
        (overflow && irq_en_q) |=> overflow_irq_flag)
        else $error("overflow missed interrupt flag");

    toggle_flip_a: assert property (@(posedge clock) // [R18]
        disable iff (!reset_n)
        overflow |=> toggle_q != $past(toggle_q))
        else $error("toggle did not flip on overflow");

    // PWM level may lag a cycle when software swaps bit 0 for bit 1
    pin_toggle_a: assert property (@(posedge clock) // [R9]
        disable iff (!reset_n)
        toggle_output_enable |-> (buzzer_pin_oe &&
        buzzer_pin_out == toggle_q &&
        (!$past(toggle_output_enable) || !pwm_q)))
        else $error("toggle does not own the pin");

    pwm_duty_a: assert property (@(posedge clock) // [R20]
        disable iff (!reset_n)
        (timer_run_bit && pwm_output_enable && !toggle_output_enable &&
        $stable(mode_q)) |=> pwm_q == ($past(count_q) < $past(reload_q)))
        else $error("pwm level wrong for duty");

    reload_read_a: assert property (@(posedge clock) // [R19]
        disable iff (!reset_n)
        (reg_read && reg_addr == `ARTC_RELOAD_OFS) |=> reg_rdata == 8'h00)
        else $error("reload register readable");
endmodule
`default_nettype wire
